// [design/vbm_ctrl.sv]
// Supply-rail monitor, fault reporting and discharge sequencer
//
// Operation
// - Command 0x33 enables both comparators, sets flag
// - Command 0x22 disables both comparators
// - Present flag set above 4V while active
// - Two 3-bit overvolt/undervolt level fields
// - Thresholds sit 12.5% around selected target
// - Overvoltage cuts supply, drains to safe-zero
// - Overvoltage fault flag only when reporting enabled
// - Unmasked fault latches summary, drives interrupt
// - Summary and overvolt flags are write-one-clear
// - Undervoltage flag, vendor alert, masked interrupt
// - Forced-drain rising edge starts drain, monitoring
// - Forced drain ends at stop level
// - Forced drain timeout stops, flags failure
// - Detach: cut sourcing first, then drain
// - Detach drain ends at stop level
// - Detach drain timeout stops, flags failure
// - Safe-zero flag live with hysteresis
// - Safe-zero change sets extended alert when unmasked
`timescale 1ns/1ps
`default_nettype none
module vbm_ctrl #(
  parameter int DRAIN_TIMEOUT_CYC = vbm_pkg::DRAIN_TIMEOUT_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [9:0] vout_code,
  input  wire logic       detach,
  output logic            supply_on,
  output logic            drain_on,
  output logic            irq_out_n
);
  import vbm_pkg::*;

  function automatic logic hit(input logic       strobe,
                               input logic [7:0] addr,
                               input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  vbm_state_t state;
  vbm_state_t next_state;
  vbm_kind_t  kind;
  vbm_kind_t  next_kind;

  logic [7:0] power_control;
  logic       forced_q;
  logic       detect_active;
  logic       present_flag;
  logic       safe_zero_flag;
  logic [7:0] supply_limit;
  logic [1:0] target_sel;
  logic [9:0] stop_level;
  logic       report_en;
  logic [2:0] fault_mask;
  logic [2:0] fault_status;
  logic [2:0] alert_high;
  logic [2:0] alert_mask;
  logic       undervolt_flag;
  logic       undervolt_mask;
  logic       ext_mask;
  logic       uv_armed;
  logic       ov_q;

  // Write decode
  wire wr_cmd   = hit(reg_wr, reg_addr, OFS_COMMAND);
  wire wr_pc    = hit(reg_wr, reg_addr, OFS_POWER_CONTROL);
  wire wr_lim   = hit(reg_wr, reg_addr, OFS_SUPPLY_LIMIT);
  wire wr_tgt   = hit(reg_wr, reg_addr, OFS_TARGET_SEL);
  wire wr_stlo  = hit(reg_wr, reg_addr, OFS_STOP_LO);
  wire wr_sthi  = hit(reg_wr, reg_addr, OFS_STOP_HI);
  wire wr_fctl  = hit(reg_wr, reg_addr, OFS_FAULT_CONTROL);
  wire wr_fmask = hit(reg_wr, reg_addr, OFS_FAULT_MASK);
  wire wr_fstat = hit(reg_wr, reg_addr, OFS_FAULT_STATUS);
  wire wr_alert = hit(reg_wr, reg_addr, OFS_ALERT_HIGH);
  wire wr_amask = hit(reg_wr, reg_addr, OFS_ALERT_MASK);
  wire wr_smask = hit(reg_wr, reg_addr, OFS_SHIELD_MASK);
  wire wr_emask = hit(reg_wr, reg_addr, OFS_EXT_MASK);
  wire wr_sctl  = hit(reg_wr, reg_addr, OFS_SUPPLY_CTRL);
  wire cmd_on   = wr_cmd && (reg_wdata == CMD_DETECT_ON);
  wire cmd_off  = wr_cmd && (reg_wdata == CMD_DETECT_OFF);

  wire [9:0] target   = TARGET_CODE[target_sel];
  wire [9:0] margin   = target >> 3;
  wire [9:0] ov_extra = 10'(supply_limit[2:0] * LEVEL_STEP_CODE);
  wire [9:0] uv_extra =
    10'(supply_limit[SL_UV_LSB +: 3] * LEVEL_STEP_CODE);
  wire [9:0] ov_thr   = target + margin + ov_extra;
  wire [9:0] uv_thr   = target - margin - uv_extra;
  wire       ov_now   = supply_on && (vout_code > ov_thr);
  wire       uv_now   = supply_on && uv_armed && (vout_code < uv_thr);
  wire       ov_ev    = ov_now && !ov_q;
  wire       uv_rise  = uv_now && !undervolt_flag;

  // Safe-zero comparator with hysteresis
  wire next_safe_zero = !detect_active ? 1'b0 :
                        (vout_code <= SAFE0_CODE) ? 1'b1 :
                        (vout_code >= SAFE0_RISE_CODE) ? 1'b0 :
                        safe_zero_flag;
  wire sz_change = detect_active && (next_safe_zero != safe_zero_flag);
  wire next_present = detect_active && (vout_code > PRESENT_CODE);

  // Drain sequencing
  wire forced_rise = power_control[PC_FORCED_BIT] && !forced_q;
  wire detach_go   = detach && power_control[PC_DETACH_BIT];
  wire reached     = (kind == VBM_KIND_OV) ? (vout_code <= SAFE0_CODE) :
                     (vout_code <= stop_level);
  wire timer_start = (state != VBM_DRAIN) && (next_state == VBM_DRAIN);
  wire expired;
  wire timed_out   = (state == VBM_DRAIN) && !reached && expired;
  wire forced_fail = timed_out && (kind == VBM_KIND_FORCED);
  wire detach_fail = timed_out && (kind == VBM_KIND_DETACH);

  always_comb
  begin
    next_state = state;
    next_kind  = kind;
    unique case (state)
      VBM_IDLE:
      begin
        if (ov_ev)
        begin
          next_state = VBM_DRAIN;
          next_kind  = VBM_KIND_OV;
        end
        else if (detach_go)
          next_state = VBM_SRC_OFF;
        else if (forced_rise)
        begin
          next_state = VBM_DRAIN;
          next_kind  = VBM_KIND_FORCED;
        end
      end
      VBM_SRC_OFF:
      begin
        next_state = VBM_DRAIN;
        next_kind  = VBM_KIND_DETACH;
      end
      VBM_DRAIN:
        if (ov_ev)
          next_kind = VBM_KIND_OV;
        else if (reached || expired)
          next_state = VBM_IDLE;
      default:
        next_state = VBM_IDLE;
    endcase
  end

  // Fault and alert set terms
  wire [2:0] fs_set   = {detach_fail, forced_fail, ov_ev && report_en};
  wire       sum_set  = |(fs_set & fault_mask);
  wire       vnd_set  = uv_rise && undervolt_mask;
  wire       ext_set  = sz_change && ext_mask;
  wire [2:0] ah_set   = {ext_set, sum_set, vnd_set};
  wire [2:0] fs_clr   = wr_fstat ? reg_wdata[2:0] : 3'h0;
  wire [2:0] ah_clr   = wr_alert ? reg_wdata[2:0] : 3'h0;
  wire [2:0] next_fs  = fs_set | (fault_status & ~fs_clr);
  wire [2:0] next_ah  = ah_set | (alert_high & ~ah_clr);
  wire       next_irq = (next_ah[AH_SUMMARY_BIT] | next_ah[AH_VENDOR_BIT])
                        & alert_mask[AH_SUMMARY_BIT]
                        | next_ah[AH_EXT_BIT] & alert_mask[AH_EXT_BIT];

  // Sourcing cut by overvoltage or armed detach
  wire src_cut = ov_ev || ((state == VBM_IDLE) && detach_go);

  vbm_drain_timer #(
    .CYCLES (DRAIN_TIMEOUT_CYC)
  ) u_timer (
    .clk     (clk),
    .resetn  (resetn),
    .start   (timer_start),
    .run     (state == VBM_DRAIN),
    .expired (expired)
  );

  assign drain_on = (state == VBM_DRAIN);

  // Read mux
  wire [7:0] rd_mux =
    (reg_addr == OFS_POWER_CONTROL) ? power_control :
    (reg_addr == OFS_POWER_STATUS)  ?
      8'({detect_active, present_flag, 2'b00}) :
    (reg_addr == OFS_EXT_STATUS)    ? {7'h00, safe_zero_flag} :
    (reg_addr == OFS_SUPPLY_LIMIT)  ? supply_limit :
    (reg_addr == OFS_TARGET_SEL)    ? {6'h00, target_sel} :
    (reg_addr == OFS_STOP_LO)       ? stop_level[7:0] :
    (reg_addr == OFS_STOP_HI)       ? {6'h00, stop_level[9:8]} :
    (reg_addr == OFS_FAULT_CONTROL) ? {7'h00, report_en} :
    (reg_addr == OFS_FAULT_MASK)    ? {5'h00, fault_mask} :
    (reg_addr == OFS_FAULT_STATUS)  ? {5'h00, fault_status} :
    (reg_addr == OFS_ALERT_HIGH)    ? {5'h00, alert_high} :
    (reg_addr == OFS_ALERT_MASK)    ? {5'h00, alert_mask} :
    (reg_addr == OFS_SHIELD_STATUS) ? {7'h00, undervolt_flag} :
    (reg_addr == OFS_SHIELD_MASK)   ? {7'h00, undervolt_mask} :
    (reg_addr == OFS_EXT_MASK)      ? {7'h00, ext_mask} :
    (reg_addr == OFS_SUPPLY_CTRL)   ? {7'h00, supply_on} :
    8'h00;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state          <= VBM_IDLE;
      kind           <= VBM_KIND_FORCED;
      power_control  <= PWR_CTRL_RST;
      forced_q       <= 1'b0;
      detect_active  <= 1'b0;
      present_flag   <= 1'b0;
      safe_zero_flag <= 1'b0;
      supply_limit   <= 8'h00;
      target_sel     <= 2'h0;
      stop_level     <= STOP_DEFAULT_CODE;
      report_en      <= 1'b0;
      fault_mask     <= FAULT_MASK_RST;
      fault_status   <= 3'h0;
      alert_high     <= 3'h0;
      alert_mask     <= ALERT_MASK_RST;
      undervolt_flag <= 1'b0;
      undervolt_mask <= 1'b1;
      ext_mask       <= 1'b1;
      uv_armed       <= 1'b0;
      ov_q           <= 1'b0;
      supply_on      <= 1'b0;
      irq_out_n      <= 1'b1;
      reg_rdata      <= 8'h00;
    end
    else
    begin
      forced_q       <= power_control[PC_FORCED_BIT];
      state          <= next_state;
      kind           <= next_kind;
      if (cmd_on)
        detect_active <= 1'b1;
      else if (cmd_off)
        detect_active <= 1'b0;
      present_flag   <= next_present;
      safe_zero_flag <= next_safe_zero;
      if (wr_pc)
        power_control <= reg_wdata & PWR_CTRL_WMASK;
      if (wr_lim)
        supply_limit <= reg_wdata;
      if (wr_tgt)
        target_sel <= reg_wdata[1:0];
      if (wr_stlo)
        stop_level[7:0] <= reg_wdata;
      if (wr_sthi)
        stop_level[9:8] <= reg_wdata[1:0];
      if (wr_fctl)
        report_en <= reg_wdata[0];
      if (wr_fmask)
        fault_mask <= reg_wdata[2:0];
      if (wr_amask)
        alert_mask <= reg_wdata[2:0];
      if (wr_smask)
        undervolt_mask <= reg_wdata[0];
      if (wr_emask)
        ext_mask <= reg_wdata[0];
      fault_status   <= next_fs;
      alert_high     <= next_ah;
      irq_out_n      <= !next_irq;
      undervolt_flag <= uv_now;
      if (!supply_on)
        uv_armed <= 1'b0;
      else if (vout_code >= uv_thr)
        uv_armed <= 1'b1;
      ov_q           <= ov_now;
      if (src_cut)
        supply_on <= 1'b0;
      else if (wr_sctl)
        supply_on <= reg_wdata[0];
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_detect_on_cmd: assert property (
    cmd_on |=> detect_active ##1 (detect_active || $past(cmd_off)))
    else $error("detect not enabled by command");
  a_detect_off_cmd: assert property (
    cmd_off |=> !detect_active ##1 !present_flag && !safe_zero_flag)
    else $error("detect not disabled by command");
  a_present_cause: assert property (
    present_flag |-> $past(detect_active) &&
                     ($past(vout_code) > PRESENT_CODE))
    else $error("present flag without cause");
  a_ov_kills_supply: assert property (
    ov_ev |=> !supply_on && drain_on && (kind == VBM_KIND_OV))
    else $error("overvoltage did not cut supply");
  a_ov_report_gate: assert property (
    $rose(fault_status[FS_OV_BIT]) |-> $past(report_en) && $past(ov_ev))
    else $error("overvolt flag set while reporting off");
  a_irq_cause: assert property (
    !irq_out_n |-> (alert_high[AH_SUMMARY_BIT] ||
                    alert_high[AH_VENDOR_BIT] ||
                    alert_high[AH_EXT_BIT]))
    else $error("interrupt with no alert");
  a_summary_w1c: assert property (
    wr_alert && reg_wdata[AH_SUMMARY_BIT] && !sum_set
      |=> !alert_high[AH_SUMMARY_BIT])
    else $error("summary flag not cleared");
  a_forced_start: assert property (
    (state == VBM_IDLE) && forced_rise && !ov_ev && !detach_go
      |=> drain_on ##1 (drain_on || $past(reached || expired)))
    else $error("forced drain did not start");
  a_stop_keeps_en: assert property (
    drain_on && reached && (kind == VBM_KIND_FORCED) && !wr_pc
      |=> !drain_on && power_control[PC_FORCED_BIT] ==
          $past(power_control[PC_FORCED_BIT]))
    else $error("forced drain stop wrong");
  a_forced_fail: assert property (
    forced_fail |=> fault_status[FS_FORCED_BIT] && !drain_on)
    else $error("forced drain timeout not flagged");
  a_detach_order: assert property (
    (state == VBM_SRC_OFF) |-> !supply_on ##1 drain_on)
    else $error("detach drain out of order");
  a_detach_fail: assert property (
    detach_fail |=> fault_status[FS_DETACH_BIT] && !drain_on)
    else $error("detach drain timeout not flagged");
  a_sz_alert: assert property (
    sz_change && ext_mask |=> alert_high[AH_EXT_BIT])
    else $error("safe-zero change alert missing");
endmodule
`default_nettype wire

// [design/vbm_pkg.sv]
// Constants and types for the supply-rail monitor and discharge control
package vbm_pkg;
  // Timing
  localparam int CLK_KHZ           = 50000;
  localparam int DRAIN_TIMEOUT_MS  = 650;
  localparam int DRAIN_TIMEOUT_CYC = DRAIN_TIMEOUT_MS * CLK_KHZ;
  // Sense code scale, millivolts per code
  localparam int MV_PER_CODE       = 25;
  localparam int PRESENT_MV        = 4000;
  localparam int SAFE0_MV          = 750;
  localparam int SAFE0_HYST_MV     = 50;
  localparam int STOP_DEFAULT_MV   = 800;
  localparam int LEVEL_STEP_MV     = 100;
  localparam logic [9:0] PRESENT_CODE = 10'(PRESENT_MV / MV_PER_CODE);
  localparam logic [9:0] SAFE0_CODE   = 10'(SAFE0_MV / MV_PER_CODE);
  localparam logic [9:0] SAFE0_RISE_CODE =
    10'((SAFE0_MV + SAFE0_HYST_MV) / MV_PER_CODE);
  localparam logic [9:0] STOP_DEFAULT_CODE =
    10'(STOP_DEFAULT_MV / MV_PER_CODE);
  localparam logic [9:0] LEVEL_STEP_CODE = 10'(LEVEL_STEP_MV / MV_PER_CODE);
  // Supply targets selected by target_voltage_sel
  localparam logic [9:0] TARGET_CODE [4] = '{10'h0C8, 10'h168, 10'h258,
                                             10'h320};
  // Register offsets
  localparam logic [7:0] OFS_ALERT_HIGH    = 8'h11;
  localparam logic [7:0] OFS_ALERT_MASK    = 8'h13;
  localparam logic [7:0] OFS_FAULT_MASK    = 8'h15;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_FAULT_CONTROL = 8'h1D;
  localparam logic [7:0] OFS_POWER_STATUS  = 8'h1E;
  localparam logic [7:0] OFS_FAULT_STATUS  = 8'h1F;
  localparam logic [7:0] OFS_EXT_STATUS    = 8'h20;
  localparam logic [7:0] OFS_COMMAND       = 8'h23;
  localparam logic [7:0] OFS_SUPPLY_LIMIT  = 8'h80;
  localparam logic [7:0] OFS_TARGET_SEL    = 8'h81;
  localparam logic [7:0] OFS_STOP_LO       = 8'h82;
  localparam logic [7:0] OFS_STOP_HI       = 8'h83;
  localparam logic [7:0] OFS_SHIELD_STATUS = 8'h84;
  localparam logic [7:0] OFS_SHIELD_MASK   = 8'h85;
  localparam logic [7:0] OFS_EXT_MASK      = 8'h86;
  localparam logic [7:0] OFS_SUPPLY_CTRL   = 8'h87;
  // Commands
  localparam logic [7:0] CMD_DETECT_ON  = 8'h33;
  localparam logic [7:0] CMD_DETECT_OFF = 8'h22;
  // Field positions
  localparam int PC_FORCED_BIT  = 2;
  localparam int PC_DETACH_BIT  = 4;
  localparam int PS_PRESENT_BIT = 2;
  localparam int PS_DETECT_BIT  = 3;
  localparam int FS_OV_BIT      = 0;
  localparam int FS_FORCED_BIT  = 1;
  localparam int FS_DETACH_BIT  = 2;
  localparam int AH_VENDOR_BIT  = 0;
  localparam int AH_SUMMARY_BIT = 1;
  localparam int AH_EXT_BIT     = 2;
  localparam int SL_UV_LSB      = 4;
  // Reset values and write masks
  localparam logic [7:0] PWR_CTRL_RST   = 8'h60;
  localparam logic [7:0] PWR_CTRL_WMASK = 8'h75;
  localparam logic [2:0] FAULT_MASK_RST = 3'h7;
  localparam logic [2:0] ALERT_MASK_RST = 3'h7;
  // Drain sequencer
  typedef enum logic [1:0] {
    VBM_IDLE    = 2'b00,
    VBM_SRC_OFF = 2'b01,
    VBM_DRAIN   = 2'b11
  } vbm_state_t;
  typedef enum logic [1:0] {
    VBM_KIND_FORCED = 2'h0,
    VBM_KIND_DETACH = 2'h1,
    VBM_KIND_OV     = 2'h2
  } vbm_kind_t;
endpackage

// [design/vbm_drain_timer.sv]
// Discharge timeout counter
`timescale 1ns/1ps
`default_nettype none
module vbm_drain_timer #(
  parameter int CYCLES = 32500000
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic start,
  input  wire logic run,
  output logic      expired
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count;

  assign expired = run && !start && (count == LAST);

  always_ff @(posedge clk)
  begin
    if (!resetn || start || !run)
      count <= '0;
    else if (count != LAST)
      count <= count + W'(1);
  end
endmodule
`default_nettype wire

// [sim/vbm_pm_model.sv]
// Port manager model driving the register port
`timescale 1ns/1ps
`default_nettype none
module vbm_pm_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released bus shows inverted values
  task automatic release_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // One-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    release_bus();
  endtask
  // Read data stands from the edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    release_bus();
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [sim/vbm_ctrl_tb_top.sv]
// Self-checking bench for the supply-rail monitor
`timescale 1ns/1ps
`default_nettype none
module vbm_ctrl_tb_top;
  import vbm_pkg::*;
  localparam int TMO = 50;
  logic        clk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic        detach;
  logic        supply_on;
  logic        drain_on;
  logic        irq_out_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_val;
  logic [9:0]  vout_code;
  logic [9:0]  stop;
  logic [15:0] lfsr;
  logic [15:0] r;
  logic [2:0]  sel;
  logic [1:0]  tsel;
  int          n_errors;
  int          n_compared;
  int          cycles;

  vbm_ctrl #(.DRAIN_TIMEOUT_CYC(TMO)) u_dut (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vout_code(vout_code), .detach(detach), .supply_on(supply_on),
    .drain_on(drain_on), .irq_out_n(irq_out_n)
  );
  vbm_pm_model u_pm (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [9:0] ov_level(logic [1:0] t, logic [2:0] s);
    return TARGET_CODE[t] + TARGET_CODE[t] / 8 + 10'(s) * 4;
  endfunction
  function automatic logic [9:0] uv_level(logic [1:0] t, logic [2:0] s);
    return TARGET_CODE[t] - TARGET_CODE[t] / 8 - 10'(s) * 4;
  endfunction
  function automatic logic sig(int k);
    return k == 0 ? supply_on : (k == 1 ? drain_on : irq_out_n);
  endfunction
  task automatic draw();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    r = lfsr;
  endtask
  task automatic chk(string w, logic [9:0] e, logic [9:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e, string w);
    u_pm.rd(a, rd_val);
    chk(w, 10'(e), 10'(rd_val));
  endtask
  task automatic wait_on(int k, logic v, int lim, string w);
    int i;
    i = 0;
    while (sig(k) !== v && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    chk(w, 10'(v), 10'(sig(k)));
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    resetn = 1'b0;
    detach = 1'b0;
    vout_code = 10'h000;
    lfsr = 16'hCA56;
    r = 16'h0000;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    // Reset values, write mask, unmapped place
    rchk(OFS_POWER_CONTROL, PWR_CTRL_RST, "pwr_ctrl_rst");
    rchk(8'h55, 8'h00, "unmapped_read");
    u_pm.wr(OFS_POWER_CONTROL, 8'hFB);
    rchk(OFS_POWER_CONTROL, 8'h71, "pwr_ctrl_mask");
    u_pm.wr(OFS_POWER_CONTROL, 8'h60);
    rchk(OFS_STOP_LO, STOP_DEFAULT_CODE[7:0], "stop_default");
    u_pm.wr(OFS_STOP_HI, 8'h03);
    rchk(OFS_STOP_HI, 8'h03, "stop_hi");
    u_pm.wr(OFS_STOP_HI, 8'h00);
    // Detection on, presence boundary, safe-zero hysteresis
    vout_code = PRESENT_CODE;
    u_pm.wr(OFS_COMMAND, CMD_DETECT_ON);
    rchk(OFS_POWER_STATUS, 8'h08, "present_at_level");
    vout_code = PRESENT_CODE + 10'h001;
    rchk(OFS_POWER_STATUS, 8'h0C, "present_above");
    vout_code = SAFE0_CODE;
    rchk(OFS_EXT_STATUS, 8'h01, "safe0_low");
    rchk(OFS_ALERT_HIGH, 8'h04, "safe0_alert");
    wait_on(2, 1'b0, 3, "safe0_irq");
    u_pm.wr(OFS_ALERT_HIGH, 8'h04);
    vout_code = SAFE0_RISE_CODE - 10'h001;
    rchk(OFS_EXT_STATUS, 8'h01, "safe0_hyst");
    vout_code = SAFE0_RISE_CODE;
    rchk(OFS_EXT_STATUS, 8'h00, "safe0_high");
    u_pm.wr(OFS_ALERT_HIGH, 8'h04);
    rchk(OFS_ALERT_HIGH, 8'h00, "ext_clear");
    u_pm.wr(OFS_COMMAND, CMD_DETECT_OFF);
    vout_code = 10'h00A;
    rchk(OFS_POWER_STATUS, 8'h00, "detect_off");
    rchk(OFS_EXT_STATUS, 8'h00, "safe0_off");
    // Forced drain ends at a random stop level
    draw();
    stop = 10'h028 + 10'(r[5:0]);
    u_pm.wr(OFS_STOP_LO, stop[7:0]);
    vout_code = stop + 10'h032;
    u_pm.wr(OFS_POWER_CONTROL, 8'h64);
    wait_on(1, 1'b1, 4, "forced_on");
    vout_code = stop + 10'h001;
    repeat (5) @(negedge clk);
    chk("forced_above_stop", 10'h001, 10'(drain_on));
    vout_code = stop;
    wait_on(1, 1'b0, 3, "forced_end");
    rchk(OFS_POWER_CONTROL, 8'h64, "forced_bit_kept");
    // Forced drain that misses the stop level
    u_pm.wr(OFS_POWER_CONTROL, 8'h60);
    vout_code = stop + 10'h032;
    u_pm.wr(OFS_POWER_CONTROL, 8'h64);
    wait_on(1, 1'b1, 4, "forced_on2");
    repeat (TMO - 8) @(negedge clk);
    chk("forced_still_on", 10'h001, 10'(drain_on));
    wait_on(1, 1'b0, 12, "forced_timeout");
    rchk(OFS_FAULT_STATUS, 8'h02, "forced_fail");
    rchk(OFS_ALERT_HIGH, 8'h02, "forced_summary");
    chk("forced_irq", 10'h000, 10'(irq_out_n));
    u_pm.wr(OFS_FAULT_STATUS, 8'h02);
    u_pm.wr(OFS_ALERT_HIGH, 8'h02);
    rchk(OFS_FAULT_STATUS, 8'h00, "forced_clear");
    wait_on(2, 1'b1, 3, "forced_irq_clear");
    // Drain on detach: pass, then timeout
    u_pm.wr(OFS_POWER_CONTROL, 8'h70);
    for (int k = 0; k < 2; k++)
    begin
      vout_code = stop + 10'h032;
      u_pm.wr(OFS_SUPPLY_CTRL, 8'h01);
      wait_on(0, 1'b1, 3, "supply_up");
      @(negedge clk);
      detach = 1'b1;
      @(negedge clk);
      detach = 1'b0;
      wait_on(0, 1'b0, 3, "detach_src_off");
      chk("detach_not_yet", 10'h000, 10'(drain_on));
      wait_on(1, 1'b1, 3, "detach_drain");
      if (k == 0)
      begin
        vout_code = stop;
        wait_on(1, 1'b0, 3, "detach_end");
        rchk(OFS_POWER_CONTROL, 8'h70, "detach_bit_kept");
      end
      else
      begin
        repeat (TMO - 8) @(negedge clk);
        chk("detach_still_on", 10'h001, 10'(drain_on));
        wait_on(1, 1'b0, 12, "detach_timeout");
        rchk(OFS_FAULT_STATUS, 8'h04, "detach_fail");
        rchk(OFS_ALERT_HIGH, 8'h02, "detach_summary");
        chk("detach_irq", 10'h000, 10'(irq_out_n));
        u_pm.wr(OFS_FAULT_STATUS, 8'h04);
        u_pm.wr(OFS_ALERT_HIGH, 8'h02);
      end
    end
    // Overvoltage at random target and level, report off then on
    draw();
    sel = r[2:0];
    tsel = r[9:8];
    u_pm.wr(OFS_SHIELD_MASK, 8'h00);
    u_pm.wr(OFS_TARGET_SEL, {6'h00, tsel});
    u_pm.wr(OFS_SUPPLY_LIMIT, {1'b0, sel, 1'b0, sel});
    for (int k = 0; k < 2; k++)
    begin
      u_pm.wr(OFS_FAULT_CONTROL, 8'(k));
      vout_code = ov_level(tsel, sel);
      u_pm.wr(OFS_SUPPLY_CTRL, 8'h01);
      repeat (3) @(negedge clk);
      chk("ov_at_level", 10'h001, 10'(supply_on));
      vout_code = ov_level(tsel, sel) + 10'h001;
      wait_on(0, 1'b0, 3, "ov_cut");
      chk("ov_drain", 10'h001, 10'(drain_on));
      vout_code = SAFE0_CODE;
      wait_on(1, 1'b0, 3, "ov_drain_end");
      rchk(OFS_FAULT_STATUS, 8'(k), "ov_report");
      rchk(OFS_ALERT_HIGH, 8'(2 * k), "ov_summary");
      chk("ov_irq", 10'(1 - k), 10'(irq_out_n));
      u_pm.wr(OFS_FAULT_STATUS, 8'h01);
      u_pm.wr(OFS_ALERT_HIGH, 8'h02);
      rchk(OFS_FAULT_STATUS, 8'h00, "ov_clear");
      rchk(OFS_ALERT_HIGH, 8'h00, "summary_clear");
    end
    // Undervoltage boundary and vendor alert
    u_pm.wr(OFS_SHIELD_MASK, 8'h01);
    vout_code = TARGET_CODE[tsel];
    u_pm.wr(OFS_SUPPLY_CTRL, 8'h01);
    vout_code = uv_level(tsel, sel) + 10'h001;
    rchk(OFS_SHIELD_STATUS, 8'h00, "uv_above");
    vout_code = uv_level(tsel, sel) - 10'h001;
    rchk(OFS_SHIELD_STATUS, 8'h01, "uv_below");
    rchk(OFS_ALERT_HIGH, 8'h01, "uv_vendor");
    chk("uv_irq", 10'h000, 10'(irq_out_n));
    u_pm.wr(OFS_ALERT_HIGH, 8'h01);
    rchk(OFS_ALERT_HIGH, 8'h00, "uv_clear");
    wait_on(2, 1'b1, 3, "uv_irq_clear");
    tally_and_finish();
  end
endmodule
`default_nettype wire
